// ---- inc/aux_conv_params.svh ----
// Constants for the auxiliary converter and temperature sensor control block.
// Assumes 7-bit register addresses and 8-bit register data on the host port.
`ifndef AUX_CONV_PARAMS_SVH
`define AUX_CONV_PARAMS_SVH

// Register addresses
`define CONFIG_ADDR        7'h0f
`define AMP_OFFSET_ADDR    7'h10
`define RESULT_ADDR        7'h11
`define TEMP_CTRL_ADDR     7'h12
`define TEMP_OFFSET_ADDR   7'h13

// Reset values
`define CONFIG_RESET       7'h00
`define AMP_OFFSET_RESET   4'h0
`define RESULT_RESET       8'h00
`define TEMP_CTRL_RESET    8'h20
`define TEMP_OFFSET_RESET  8'h00
`define READ_ZERO          8'h00

// Converter configuration fields
`define START_BIT          7
`define SEL_HI             6
`define SEL_LO             4
`define REF_HI             3
`define REF_LO             2
`define GAIN_HI            1
`define GAIN_LO            0
`define AMP_OFFSET_HI      3

// Temperature sensor control fields
`define RANGE_HI           7
`define RANGE_LO           6
`define SHIFT_EN_BIT       5
`define TRIM_EN_BIT        4
`define TRIM_HI            3
`define TRIM_LO            0

// Input code of the temperature sensor
`define SEL_TEMP_SENSOR    3'h0

// Timing: conversion time and clock period
`define CONV_TIME_NS       350000
`define CLK_PERIOD_NS      10

// Successive approximation: eight trial slots plus one settle slot
`define SAR_SLOTS          9
`define CODE_MSB           8'h80
`define CODE_NONE          8'h00
`define COUNT_ONE          16'h0001

`endif

// ---- inc/aux_conv_pkg.sv ----
// Types shared by the converter control block and its sequencer.
// Assumes the constants header sits on the include path.
`include "aux_conv_params.svh"

package aux_conv_pkg;

    // One host port request, sampled on a single clock edge
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Settings handed to the analog converter and sensor
    typedef struct packed {
        logic [2:0] input_select;
        logic [1:0] reference;
        logic [1:0] gain;
        logic [3:0] amp_offset;
        logic       temp_sensor_en;
        logic [1:0] temp_range;
        logic       temp_shift_enable_default;
        logic       trim_enable;
        logic [3:0] bandgap_trim;
        logic [7:0] temp_value_offset;
    } analog_ctrl_type;

    // Sequencer states
    typedef enum logic {
        SAR_IDLE = 1'b0,
        SAR_RUN  = 1'b1
    } sar_state_type;

endpackage

// ---- hw/sar_sequencer.sv ----
// Successive approximation sequencer for the eight_bit_converter.
// Assumes comp_in is high while the analog input lies at or above trial_out.
`timescale 1ns/1ns
`include "aux_conv_params.svh"

module sar_sequencer #(
    parameter int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       resetn_in,
    // Control
    input  wire logic       start_in,
    input  wire logic       comp_in,
    // Status and data
    output logic            busy_out,
    output logic            done_out,
    output logic [7:0]      result_out,
    output logic [7:0]      trial_out
);
    localparam int STEP_RAW = CONV_CYCLES / `SAR_SLOTS;
    localparam int STEP     = (STEP_RAW < 1) ? 1 : STEP_RAW;
    localparam logic [15:0] LAST      = 16'(CONV_CYCLES - 1);
    localparam logic [15:0] STEP_LAST = 16'(STEP - 1);

    aux_conv_pkg::sar_state_type state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [15:0] step_cnt, next_step_cnt;
    logic [7:0]  mask, next_mask;
    logic [7:0]  code, next_code;
    logic [7:0]  kept;

    assign busy_out   = (state == aux_conv_pkg::SAR_RUN);
    assign done_out   = busy_out && (cnt == LAST);
    assign result_out = code;
    assign trial_out  = code;

    // Next state; the bit trials finish before the fixed conversion time ends
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_step_cnt = step_cnt;
        next_mask     = mask;
        next_code     = code;
        kept          = comp_in ? code : (code & ~mask);
        unique case (state)
            aux_conv_pkg::SAR_IDLE: begin
            end
            aux_conv_pkg::SAR_RUN: begin
                if (cnt == LAST) begin
                    next_state = aux_conv_pkg::SAR_IDLE;
                end else begin
                    next_cnt = cnt + `COUNT_ONE;
                end
                if (step_cnt == STEP_LAST) begin
                    next_step_cnt = 16'h0000;
                    if (mask != `CODE_NONE) begin
                        next_code = kept | (mask >> 1);
                        next_mask = mask >> 1;
                    end
                end else begin
                    next_step_cnt = step_cnt + `COUNT_ONE;
                end
            end
        endcase
        // A new start restarts the whole sequence, even on the final cycle
        if (start_in) begin
            next_state    = aux_conv_pkg::SAR_RUN;
            next_cnt      = 16'h0000;
            next_step_cnt = 16'h0000;
            next_mask     = `CODE_MSB;
            next_code     = `CODE_MSB;
        end
    end

    // Registers
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            state    <= aux_conv_pkg::SAR_IDLE;
            cnt      <= 16'h0000;
            step_cnt <= 16'h0000;
            mask     <= `CODE_NONE;
            code     <= `CODE_NONE;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            step_cnt <= next_step_cnt;
            mask     <= next_mask;
            code     <= next_code;
        end
    end

    property p_trial_msb_first;
        @(posedge core_clk_in) disable iff (!resetn_in)
        start_in |=> (trial_out == `CODE_MSB) && busy_out;
    endproperty
    a_trial_msb_first: assert property (p_trial_msb_first)
        else $error("trial code does not start at the top bit");

endmodule

// ---- hw/aux_adc_temp_sensor_ctrl.sv ----
// Register file and control for the auxiliary converter and temperature sensor.
// Assumes host port requests are synchronous to core_clk_in, one per cycle.
//
// Behaviour
// - Eight-bit unsigned result in read-only register.
// - Three-bit select; code 000 picks sensor.
// - Default reference is internal bandgap.
// - Software sets start; hardware clears it.
// - Conversion lasts 350 us; busy throughout.
// - Two-bit gain field drives amplifier gain.
// - Four-bit coarse offset field drives amplifier.
// - Sensor enabled whenever select chooses it.
// - Range field selects temperature scale and step.
// - Shift enable off gives absolute mode; resets one.
// - Trim field, gated by enable, tunes bandgap.
// - Any reset restores all register defaults.
`timescale 1ns/1ns
`include "aux_conv_params.svh"

module aux_adc_temp_sensor_ctrl #(
    parameter int CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                          core_clk_in,
    input  wire logic                          resetn_in,
    // Host register port
    input  wire aux_conv_pkg::reg_req_type     reg_req_in,
    output aux_conv_pkg::reg_req_type          unused_req_out,
    output logic [7:0]                         reg_rdata_out,
    // Analog converter side
    input  wire logic                          comp_in,
    output logic [7:0]                         trial_code_out,
    output logic                               conv_busy_out,
    output aux_conv_pkg::analog_ctrl_type      analog_ctrl_out
);
    logic [6:0] cfg, next_cfg;
    logic [3:0] amp_offset, next_amp_offset;
    logic [7:0] result, next_result;
    logic [7:0] temp_ctrl, next_temp_ctrl;
    logic [7:0] temp_offset, next_temp_offset;
    logic [7:0] next_rdata;
    aux_conv_pkg::analog_ctrl_type next_ctrl;
    aux_conv_pkg::reg_req_type     next_echo;
    logic       busy;
    logic       done;
    logic       start_req;
    logic [7:0] sar_result;
    logic       wr_cfg;

    // Conversion sequencer
    sar_sequencer #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_sar (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .start_in    (start_req),
        .comp_in     (comp_in),
        .busy_out    (busy),
        .done_out    (done),
        .result_out  (sar_result),
        .trial_out   (trial_code_out)
    );

    assign conv_busy_out = busy;

    // Register writes and conversion start
    always_comb begin
        wr_cfg           = reg_req_in.wr && (reg_req_in.addr == `CONFIG_ADDR);
        start_req        = wr_cfg && reg_req_in.wdata[`START_BIT] && (!busy || done);
        next_cfg         = wr_cfg ? reg_req_in.wdata[`SEL_HI:`GAIN_LO] : cfg;
        next_amp_offset  = amp_offset;
        next_temp_ctrl   = temp_ctrl;
        next_temp_offset = temp_offset;
        if (reg_req_in.wr && (reg_req_in.addr == `AMP_OFFSET_ADDR)) begin
            next_amp_offset = reg_req_in.wdata[`AMP_OFFSET_HI:0];
        end
        if (reg_req_in.wr && (reg_req_in.addr == `TEMP_CTRL_ADDR)) begin
            next_temp_ctrl = reg_req_in.wdata;
        end
        if (reg_req_in.wr && (reg_req_in.addr == `TEMP_OFFSET_ADDR)) begin
            next_temp_offset = reg_req_in.wdata;
        end
        next_result = done ? sar_result : result;
    end

    // Analog settings follow the registers; the sensor powers only when selected
    always_comb begin
        next_ctrl.input_select              = next_cfg[`SEL_HI:`SEL_LO];
        next_ctrl.reference                 = next_cfg[`REF_HI:`REF_LO];
        next_ctrl.gain                      = next_cfg[`GAIN_HI:`GAIN_LO];
        next_ctrl.amp_offset                = next_amp_offset;
        next_ctrl.temp_sensor_en            = (next_cfg[`SEL_HI:`SEL_LO] == `SEL_TEMP_SENSOR);
        next_ctrl.temp_range                = next_temp_ctrl[`RANGE_HI:`RANGE_LO];
        next_ctrl.temp_shift_enable_default = next_temp_ctrl[`SHIFT_EN_BIT];
        next_ctrl.trim_enable               = next_temp_ctrl[`TRIM_EN_BIT];
        next_ctrl.bandgap_trim              = next_temp_ctrl[`TRIM_HI:`TRIM_LO];
        next_ctrl.temp_value_offset         = next_temp_offset;
    end

    // Read data, one cycle after the read strobe; unmapped addresses read zero
    always_comb begin
        next_rdata = reg_rdata_out;
        next_echo  = reg_req_in;
        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                `CONFIG_ADDR:      next_rdata = {busy, cfg};
                `AMP_OFFSET_ADDR:  next_rdata = {4'h0, amp_offset};
                `RESULT_ADDR:      next_rdata = result;
                `TEMP_CTRL_ADDR:   next_rdata = temp_ctrl;
                `TEMP_OFFSET_ADDR: next_rdata = temp_offset;
                default:           next_rdata = `READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            cfg             <= `CONFIG_RESET;
            amp_offset      <= `AMP_OFFSET_RESET;
            result          <= `RESULT_RESET;
            temp_ctrl       <= `TEMP_CTRL_RESET;
            temp_offset     <= `TEMP_OFFSET_RESET;
            reg_rdata_out   <= `READ_ZERO;
            unused_req_out  <= '0;
            analog_ctrl_out <= {3'h0, 2'h0, 2'h0, 4'h0, 1'b1, 2'h0, 1'b1, 1'b0, 4'h0, 8'h00};
        end else begin
            cfg             <= next_cfg;
            amp_offset      <= next_amp_offset;
            result          <= next_result;
            temp_ctrl       <= next_temp_ctrl;
            temp_offset     <= next_temp_offset;
            reg_rdata_out   <= next_rdata;
            unused_req_out  <= next_echo;
            analog_ctrl_out <= next_ctrl;
        end
    end

    // Helper: length of the current busy interval
    logic [15:0] busy_len;
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            busy_len <= 16'h0000;
        end else begin
            // A start, fresh or on the final cycle, opens a new interval at zero
            busy_len <= start_req ? 16'h0000 : (busy ? busy_len + `COUNT_ONE : 16'h0000);
        end
    end
    localparam logic [15:0] CONV_LEN = 16'(CONV_CYCLES);

    property p_start_sets_busy;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (wr_cfg && reg_req_in.wdata[`START_BIT] && !busy) |=> busy ##0 conv_busy_out;
    endproperty
    a_start_sets_busy: assert property (p_start_sets_busy)
        else $error("start write did not set busy");

    property p_busy_length;
        @(posedge core_clk_in) disable iff (!resetn_in)
        $fell(busy) |-> (busy_len == CONV_LEN);
    endproperty
    a_busy_length: assert property (p_busy_length)
        else $error("busy interval differs from conversion time");

    property p_result_holds;
        @(posedge core_clk_in) disable iff (!resetn_in)
        !done |=> $stable(result);
    endproperty
    a_result_holds: assert property (p_result_holds)
        else $error("result changed without a finished conversion");

    property p_result_loads;
        @(posedge core_clk_in) disable iff (!resetn_in)
        done |=> (result == $past(sar_result)) && !busy || $past(start_req);
    endproperty
    a_result_loads: assert property (p_result_loads)
        else $error("result not loaded at end of conversion");

    property p_sensor_enable;
        @(posedge core_clk_in) disable iff (!resetn_in)
        analog_ctrl_out.temp_sensor_en == (cfg[`SEL_HI:`SEL_LO] == `SEL_TEMP_SENSOR);
    endproperty
    a_sensor_enable: assert property (p_sensor_enable)
        else $error("sensor enable does not follow input select");

    property p_select_routed;
        @(posedge core_clk_in) disable iff (!resetn_in)
        wr_cfg |=> analog_ctrl_out.input_select == $past(reg_req_in.wdata[`SEL_HI:`SEL_LO]);
    endproperty
    a_select_routed: assert property (p_select_routed)
        else $error("input select not routed to converter");

    property p_gain_ref_routed;
        @(posedge core_clk_in) disable iff (!resetn_in)
        analog_ctrl_out.gain == cfg[`GAIN_HI:`GAIN_LO] &&
        analog_ctrl_out.reference == cfg[`REF_HI:`REF_LO];
    endproperty
    a_gain_ref_routed: assert property (p_gain_ref_routed)
        else $error("gain or reference not routed");

    property p_offset_routed;
        @(posedge core_clk_in) disable iff (!resetn_in)
        analog_ctrl_out.amp_offset == amp_offset;
    endproperty
    a_offset_routed: assert property (p_offset_routed)
        else $error("coarse offset not routed");

    property p_temp_fields;
        @(posedge core_clk_in) disable iff (!resetn_in)
        {analog_ctrl_out.temp_range, analog_ctrl_out.temp_shift_enable_default,
         analog_ctrl_out.trim_enable, analog_ctrl_out.bandgap_trim} == temp_ctrl;
    endproperty
    a_temp_fields: assert property (p_temp_fields)
        else $error("temperature control fields not routed");

    property p_reset_defaults;
        @(posedge core_clk_in)
        !resetn_in |=> cfg == `CONFIG_RESET && temp_ctrl == `TEMP_CTRL_RESET &&
                       analog_ctrl_out.temp_shift_enable_default && !busy &&
                       analog_ctrl_out.reference == 2'h0;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("reset did not restore defaults");

    property p_busy_readback;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (reg_req_in.rd && reg_req_in.addr == `CONFIG_ADDR) |=>
            reg_rdata_out[`START_BIT] == $past(busy);
    endproperty
    a_busy_readback: assert property (p_busy_readback)
        else $error("start bit readback does not show busy");

    c_conversion_done: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        done ##1 !busy);
    c_temp_measure: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        start_req && analog_ctrl_out.temp_sensor_en);
    c_restart_at_done: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        start_req && done);

endmodule

// ---- testbench/analog_model.sv ----
// Behavioural comparator standing in for the analog front end of the converter.
// Assumes the bench sets level_in as the held input voltage, one code per step.
`timescale 1ns/1ns

module analog_model (
    // Trial code from the sequencer
    input  wire logic [7:0] trial_in,
    // Held analog input, in converter codes
    input  wire logic [7:0] level_in,
    // Comparator decision
    output logic            comp_out
);
    // High while the input lies at or above the trial; ideal, no noise or offset
    assign comp_out = (level_in >= trial_in);
endmodule

// ---- testbench/aux_adc_temp_sensor_ctrl_tb_top.sv ----
// Self-checking bench for the converter and temperature sensor register block.
// Assumes the design header sits on the include path and a shortened conversion count.
`timescale 1ns/1ns

module aux_adc_temp_sensor_ctrl_tb_top;
    localparam int CONV = 27;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp_rd;
    } row_type;

    logic                          core_clk_in;
    logic                          resetn_in;
    logic                          comp_in;
    aux_conv_pkg::reg_req_type     reg_req_in;
    aux_conv_pkg::reg_req_type     echo_req;
    logic [7:0]                    reg_rdata_out;
    logic [7:0]                    trial_code_out;
    logic [7:0]                    level;
    logic                          conv_busy_out;
    aux_conv_pkg::analog_ctrl_type analog_ctrl_out;
    aux_conv_pkg::analog_ctrl_type exp_ac;
    int                            failures;
    int                            total_checks;
    int                            cycles;
    int                            busy_cnt;
    row_type                       rows [6];

    aux_adc_temp_sensor_ctrl #(.CONV_CYCLES(CONV)) aux_adc_temp_sensor_ctrl_inst (
        .core_clk_in     (core_clk_in),
        .resetn_in       (resetn_in),
        .reg_req_in      (reg_req_in),
        .unused_req_out  (echo_req),
        .reg_rdata_out   (reg_rdata_out),
        .comp_in         (comp_in),
        .trial_code_out  (trial_code_out),
        .conv_busy_out   (conv_busy_out),
        .analog_ctrl_out (analog_ctrl_out)
    );

    analog_model analog_model_inst (
        .trial_in (trial_code_out),
        .level_in (level),
        .comp_out (comp_in)
    );

    // Free-running 100 MHz clock
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Busy cycle count and hang guard; old busy value is read before the design updates
    always @(posedge core_clk_in) begin
        cycles++;
        if (conv_busy_out === 1'b1) begin
            busy_cnt++;
        end
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, driven between falling edges
    task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_req_in = {1'b1, 1'b0, a, d};
        @(negedge core_clk_in);
        reg_req_in = '0;
    endtask

    // Read data is registered, so it is settled by the next falling edge
    task automatic reg_read(input logic [6:0] a, input logic [7:0] exp);
        @(negedge core_clk_in);
        reg_req_in = {1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk_in);
        reg_req_in = '0;
        check_val(reg_rdata_out, exp);
    endtask

    // Bounded wait for the start bit to clear
    task automatic wait_idle;
        for (int i = 0; i < CONV + 20 && conv_busy_out !== 1'b0; i++) begin
            @(negedge core_clk_in);
        end
    endtask

    // Full conversion against a fixed analog level
    task automatic run_conv(input logic [7:0] lv);
        level = lv;
        busy_cnt = 0;
        reg_write(7'h0f, 8'h80);
        check_val(conv_busy_out, 1);
        reg_read(7'h0f, 8'h80);
        wait_idle();
        check_val(busy_cnt, CONV);
        reg_read(7'h11, lv);
        reg_read(7'h0f, 8'h00);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        resetn_in = 1'b0;
        reg_req_in = '0;
        level = 8'hb3;
        failures = 0;
        total_checks = 0;
        cycles = 0;
        busy_cnt = 0;
        rows[0] = '{7'h10, 8'hff, 8'h0f};
        rows[1] = '{7'h12, 8'h5a, 8'h5a};
        rows[2] = '{7'h13, 8'ha5, 8'ha5};
        rows[3] = '{7'h11, 8'h77, 8'h00};
        rows[4] = '{7'h0f, 8'h7f, 8'h7f};
        rows[5] = '{7'h20, 8'h12, 8'h00};
        repeat (2) @(negedge core_clk_in);
        resetn_in = 1'b1;
        // Defaults after reset
        exp_ac = '0;
        exp_ac.temp_sensor_en = 1'b1;
        exp_ac.temp_shift_enable_default = 1'b1;
        check_val(analog_ctrl_out, exp_ac);
        check_val(echo_req, 0);
        reg_read(7'h0f, 8'h00);
        reg_read(7'h10, 8'h00);
        reg_read(7'h11, 8'h00);
        reg_read(7'h12, 8'h20);
        reg_read(7'h13, 8'h00);
        // Register cases, read-only result and unmapped address included: write, then read back
        foreach (rows[i]) begin
            reg_write(rows[i].addr, rows[i].wdata);
            reg_read(rows[i].addr, rows[i].exp_rd);
        end
        exp_ac = '0;
        exp_ac.input_select = 3'h7;
        exp_ac.reference = 2'h3;
        exp_ac.gain = 2'h3;
        exp_ac.amp_offset = 4'hf;
        exp_ac.temp_range = 2'h1;
        exp_ac.trim_enable = 1'b1;
        exp_ac.bandgap_trim = 4'ha;
        exp_ac.temp_value_offset = 8'ha5;
        check_val(analog_ctrl_out, exp_ac);
        reg_write(7'h0f, 8'h00);
        check_val(analog_ctrl_out.temp_sensor_en, 1);
        // Conversions at mid scale and both ends
        run_conv(8'hb3);
        run_conv(8'hff);
        run_conv(8'h00);
        run_conv(8'hb3);
        // Start while busy is ignored, other bits land, old result holds
        level = 8'h2c;
        busy_cnt = 0;
        reg_write(7'h0f, 8'h80);
        reg_read(7'h11, 8'hb3);
        reg_write(7'h0f, 8'h85);
        reg_read(7'h11, 8'hb3);
        wait_idle();
        check_val(busy_cnt, CONV);
        reg_read(7'h0f, 8'h05);
        reg_read(7'h11, 8'h2c);
        // Start written in the final busy cycle restarts; the first result still lands
        level = 8'h3c;
        busy_cnt = 0;
        reg_write(7'h0f, 8'h80);
        repeat (CONV - 2) @(negedge core_clk_in);
        reg_write(7'h0f, 8'h80);
        check_val(conv_busy_out, 1);
        reg_read(7'h11, 8'h3c);
        wait_idle();
        check_val(busy_cnt, 2 * CONV);
        reg_read(7'h11, 8'h3c);
        // Temperature reading in the order software must follow: 25 C on range 00
        reg_write(7'h0f, 8'h00);
        reg_write(7'h12, 8'h00);
        reg_write(7'h12, 8'h20);
        check_val(analog_ctrl_out.temp_shift_enable_default, 1);
        run_conv(8'((25 + 64) * 2));
        // Reset in mid conversion restores defaults
        reg_write(7'h12, 8'h00);
        level = 8'h55;
        reg_write(7'h0f, 8'h80);
        repeat (4) @(negedge core_clk_in);
        resetn_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        resetn_in = 1'b1;
        check_val(conv_busy_out, 0);
        reg_read(7'h11, 8'h00);
        reg_read(7'h12, 8'h20);
        reg_read(7'h0f, 8'h00);
        tally_and_finish();
    end
endmodule
